/* File: spcr_pkg.sv */
// Shared constants and types of the power, clock and reset controller.
// Assumes a 50 MHz system clock and byte addresses on an APB port.
package spcr_pkg;
    localparam int SPCR_AW = 8;
    // Register byte offsets
    localparam logic [7:0] SPCR_PWR_CTRL = 8'h00;
    localparam logic [7:0] SPCR_PWR_STAT = 8'h04;
    localparam logic [7:0] SPCR_CLK_SEL = 8'h08;
    localparam logic [7:0] SPCR_IMO_CFG = 8'h0c;
    localparam logic [7:0] SPCR_IMO_TGT = 8'h10;
    localparam logic [7:0] SPCR_IMO_TRIM = 8'h14;
    localparam logic [7:0] SPCR_WDT_CTRL = 8'h18;
    localparam logic [7:0] SPCR_WDT_MATCH = 8'h1c;
    localparam logic [7:0] SPCR_WDT_COUNT = 8'h20;
    localparam logic [7:0] SPCR_RST_CAUSE = 8'h24;
    localparam logic [7:0] SPCR_SW_RESET = 8'h28;
    localparam logic [7:0] SPCR_INT_STAT = 8'h2c;
    localparam logic [7:0] SPCR_INT_MASK = 8'h30;
    localparam logic [5:0] SPCR_DIV_WORD0 = 6'h10;
    // Dividers
    localparam int SPCR_NUM_DIV = 18;
    localparam int SPCR_NUM_INT_DIV = 12;
    localparam int SPCR_NUM_FRAC16 = 5;
    localparam int SPCR_DIV_W16 = 16;
    localparam int SPCR_DIV_W24 = 24;
    localparam int SPCR_FRAC_W = 5;
    localparam int SPCR_DIV_FRAC_LSB = 24;
    localparam int SPCR_DIV_EN_BIT = 31;
    // Field positions
    localparam int SPCR_IMO_LOCK_BIT = 8;
    localparam int SPCR_WDT_EN_BIT = 0;
    localparam int SPCR_WDT_RSTEN_BIT = 1;
    localparam int SPCR_WDT_WCO_BIT = 2;
    localparam int SPCR_CAUSE_WDT = 0;
    localparam int SPCR_CAUSE_SW = 1;
    localparam int SPCR_CAUSE_PIN = 2;
    localparam int SPCR_CAUSE_BOD = 3;
    localparam int SPCR_EV_WAKE = 0;
    localparam int SPCR_EV_WDT = 1;
    localparam int SPCR_EV_CLK = 2;
    // Reset values
    localparam logic [2:0] SPCR_IMO_CODE_RST = 3'h0;
    localparam logic [2:0] SPCR_IMO_CODE_MAX = 3'h6;
    localparam logic [7:0] SPCR_IMO_TRIM_RST = 8'h80;
    localparam logic [11:0] SPCR_IMO_TGT_RST = 12'h5b9;
    localparam logic [31:0] SPCR_WDT_MATCH_RST = 32'h0000ffff;
    // Timing
    localparam int SPCR_CLK_MHZ = 50;
    localparam int SPCR_WAKE_US = 35;
    localparam int SPCR_WAKE_CYC = SPCR_WAKE_US * SPCR_CLK_MHZ;
    localparam int SPCR_RST_HOLD_CYC = 16;
    localparam int SPCR_SW_GAP_CYC = 4;
    localparam int SPCR_IMO_BASE_MHZ = 24;
    localparam int SPCR_IMO_STEP_MHZ = 4;

    typedef enum logic [2:0] {
        SPCR_HOLD = 3'b000,
        SPCR_ACTIVE = 3'b001,
        SPCR_SLEEP = 3'b010,
        SPCR_DEEP = 3'b011,
        SPCR_WAKE = 3'b100
    } spcr_mode_t;

    typedef enum logic [1:0] {
        SPCR_SRC_IMO = 2'b00,
        SPCR_SRC_ECO = 2'b01,
        SPCR_SRC_EXT = 2'b10,
        SPCR_SRC_PLL = 2'b11
    } spcr_src_t;

    typedef struct packed {
        logic cpu_pwr;
        logic hf_clk;
        logic periph_clk;
        logic cpu_clk;
    } spcr_gate_t;
endpackage

/* File: spcr_top.sv */
// Power mode sequencer, root clock switch, peripheral dividers, oscillator
// lock, watchdog and reset control with an APB register port.
// Assumes oscillator, supply and wake inputs are asynchronous to clock.
// Functional notes
// - Three modes Active, Sleep, Deep Sleep; controller owns all transitions.
// - Active: every subsystem clock enabled.
// - Sleep: gate processor clock, keep peripherals; wake event returns Active.
// - Deep Sleep: high-speed clock off; wake-up takes 35 us.
// - Hold mode entry until supply good; brown-out causes reset.
// - Wake logic works in Deep Sleep with processor power off.
// - Root clock source switches without glitch or runt pulse.
// - Signals crossing domains are synchronised before use.
// - Eighteen dividers: twelve 16-bit integer, five 16-bit and one 24-bit frac.
// - Main oscillator starts at 24 MHz, selectable to 48 MHz in 4 MHz steps.
// - Option locks main oscillator to the 32 kHz watch crystal.
// - Watchdog counts low-power oscillator, resets system on missed service.
// - Watchdog reset logged in readable reset cause register.
// - Reset cause survives the reset it reports.
// - All resets, software too, asynchronous and return logic to known state; sources other than rst set sys_reset on a clock edge.
// - Watchdog counter usable as real-time clock from watch crystal.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module spcr_top #(
    parameter int NUM_DIV = 18,
    parameter int WAKE_CYC = spcr_pkg::SPCR_WAKE_CYC,
    parameter int RST_HOLD = spcr_pkg::SPCR_RST_HOLD_CYC
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic [spcr_pkg::SPCR_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and analog monitors
    input wire logic external_reset_n,
    input wire logic supply_good,
    input wire logic brownout,
    input wire logic internal_low_power_osc,
    input wire logic watch_crystal_osc,
    // Processor side
    input wire logic sleep_req,
    input wire logic [7:0] wake_irq,
    // Controls out
    output spcr_pkg::spcr_gate_t gate,
    output spcr_pkg::spcr_mode_t power_mode,
    output spcr_pkg::spcr_src_t root_src,
    output logic root_clk_on,
    output logic [NUM_DIV-1:0] div_clk_en,
    output logic [2:0] imo_freq_code,
    output logic [7:0] imo_trim,
    output logic sys_reset,
    output logic irq
);
    import spcr_pkg::*;

    localparam int NSYNC = 13;
    localparam logic [NSYNC-1:0] SYNC_RST = 13'h0001;

    // Input synchronisers, ext_n at bit 0
    logic [NSYNC-1:0] async_in, sync1_r, sync2_r;
    logic [1:0] osc_d_r;
    assign async_in = {wake_irq, watch_crystal_osc, internal_low_power_osc,
                       brownout, supply_good, external_reset_n};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            osc_d_r <= 2'h0;
        end else if (ce) begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
            osc_d_r <= sync2_r[4:3];
        end
    end
    wire ext_n_s = sync2_r[0];
    wire supply_s = sync2_r[1];
    wire brown_s = sync2_r[2];
    wire ilo_rise = sync2_r[3] & ~osc_d_r[0];
    wire wco_rise = sync2_r[4] & ~osc_d_r[1];
    wire wake_any = |sync2_r[12:5];

    // APB decode
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_r;
    wire wr_en = access & pwrite;
    wire rd_en = access & ~pwrite;
    wire [5:0] word = paddr[7:2];
    wire [5:0] div_off = word - SPCR_DIV_WORD0;
    wire div_hit = (word >= SPCR_DIV_WORD0) &&
                   (div_off < 6'(NUM_DIV));
    wire [4:0] div_idx = div_off[4:0];
    wire ctl_hit = paddr <= SPCR_INT_MASK;
    wire addr_ok = (paddr[1:0] == 2'h0) & (div_hit | ctl_hit);
    wire wr_ctl = wr_en & (paddr == SPCR_PWR_CTRL);
    wire wr_clk = wr_en & (paddr == SPCR_CLK_SEL);
    wire wr_imo = wr_en & (paddr == SPCR_IMO_CFG);
    wire wr_tgt = wr_en & (paddr == SPCR_IMO_TGT);
    wire wr_wctl = wr_en & (paddr == SPCR_WDT_CTRL);
    wire wr_wmat = wr_en & (paddr == SPCR_WDT_MATCH);
    wire wr_wcnt = wr_en & (paddr == SPCR_WDT_COUNT);
    wire wr_cause = wr_en & (paddr == SPCR_RST_CAUSE);
    wire wr_swr = wr_en & (paddr == SPCR_SW_RESET) & pwdata[0];
    wire wr_mask = wr_en & (paddr == SPCR_INT_MASK);
    wire rd_stat = rd_en & (paddr == SPCR_INT_STAT);

    // Reset generation; only power-on rst resets it
    logic sys_reset_r, sw_rst_r, wdt_fire_r;
    logic [7:0] rst_cnt_r;
    logic [3:0] cause_r;
    wire [3:0] cause_set = {brown_s, ~ext_n_s, sw_rst_r, wdt_fire_r};
    wire rst_src = |cause_set;
    wire [3:0] cause_clr = wr_cause ? pwdata[3:0] : 4'h0;
    wire [3:0] cause_nxt = (cause_r & ~cause_clr) | cause_set;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_reset_r <= 1'b1;
            rst_cnt_r <= 8'(RST_HOLD);
            cause_r <= 4'h0;
        end else if (ce) begin
            cause_r <= cause_nxt;
            if (rst_src) begin
                // Pin held low keeps reloading the hold count
                sys_reset_r <= 1'b1;
                rst_cnt_r <= 8'(RST_HOLD);
            end else if (rst_cnt_r != 8'h0) begin
                rst_cnt_r <= rst_cnt_r - 8'h1;
            end else begin
                sys_reset_r <= 1'b0;
            end
        end
    end
    // Everything below restarts from its reset value on any source
    wire lrst = rst | sys_reset_r;

    // Power mode sequencer
    spcr_mode_t mode_r, mode_nxt;
    logic [11:0] wake_cnt_r;
    logic deep_sel_r;
    spcr_gate_t gate_r, gate_nxt;
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            SPCR_HOLD: if (supply_s) mode_nxt = SPCR_ACTIVE;
            SPCR_ACTIVE: if (sleep_req) begin
                mode_nxt = deep_sel_r ? SPCR_DEEP : SPCR_SLEEP;
            end
            SPCR_SLEEP: if (wake_any) mode_nxt = SPCR_ACTIVE;
            SPCR_DEEP: if (wake_any) mode_nxt = SPCR_WAKE;
            SPCR_WAKE: if (wake_cnt_r == 12'h0) mode_nxt = SPCR_ACTIVE;
            default: mode_nxt = SPCR_HOLD;
        endcase
    end
    assign gate_nxt.cpu_clk = mode_nxt == SPCR_ACTIVE;
    assign gate_nxt.periph_clk = (mode_nxt == SPCR_ACTIVE) |
                                 (mode_nxt == SPCR_SLEEP);
    assign gate_nxt.hf_clk = (mode_nxt != SPCR_DEEP) &
                             (mode_nxt != SPCR_HOLD);
    assign gate_nxt.cpu_pwr = gate_nxt.hf_clk;
    always_ff @(posedge clock or posedge lrst) begin
        if (lrst) begin
            mode_r <= SPCR_HOLD;
            wake_cnt_r <= 12'h0;
            gate_r <= '0;
        end else if (ce) begin
            mode_r <= mode_nxt;
            gate_r <= gate_nxt;
            if (mode_nxt == SPCR_WAKE && mode_r == SPCR_DEEP) begin
                wake_cnt_r <= 12'(WAKE_CYC - 1);
            end else if (wake_cnt_r != 12'h0) begin
                wake_cnt_r <= wake_cnt_r - 12'h1;
            end
        end
    end

    // Root clock switch: gate off, settle, swap, settle, gate on
    spcr_src_t src_req_r, src_r;
    logic root_on_r;
    logic [2:0] sw_cnt_r;
    wire src_diff = src_req_r != src_r;
    wire root_start = ~root_on_r & (sw_cnt_r == 3'h0) & ~src_diff &
                      gate_r.hf_clk;
    always_ff @(posedge clock or posedge lrst) begin
        if (lrst) begin
            src_req_r <= SPCR_SRC_IMO;
            src_r <= SPCR_SRC_IMO;
            root_on_r <= 1'b0;
            sw_cnt_r <= 3'h0;
        end else if (ce) begin
            if (wr_clk) src_req_r <= spcr_src_t'(pwdata[1:0]);
            if (root_on_r) begin
                if (src_diff | ~gate_r.hf_clk) begin
                    root_on_r <= 1'b0;
                    sw_cnt_r <= 3'(SPCR_SW_GAP_CYC);
                end
            end else if (sw_cnt_r != 3'h0) begin
                sw_cnt_r <= sw_cnt_r - 3'h1;
            end else if (src_diff) begin
                // Source changes only while the output is held low
                src_r <= src_req_r;
                sw_cnt_r <= 3'(SPCR_SW_GAP_CYC);
            end else if (root_start) begin
                root_on_r <= 1'b1;
            end
        end
    end

    // Peripheral dividers; pulses are clock enables on the root clock
    logic [31:0] div_cfg_r [NUM_DIV];
    logic [NUM_DIV-1:0] div_en_r;
    for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
        localparam int IW = (i == NUM_DIV - 1) ? SPCR_DIV_W24 : SPCR_DIV_W16;
        localparam bit FRAC = i >= SPCR_NUM_INT_DIV;
        logic [23:0] cnt_r;
        logic [4:0] acc_r;
        logic extra_r;
        wire [23:0] int_val = 24'(div_cfg_r[i][IW-1:0]);
        wire [4:0] frac_val = FRAC ?
            div_cfg_r[i][SPCR_DIV_FRAC_LSB +: SPCR_FRAC_W] : 5'h0;
        wire [5:0] acc_sum = {1'b0, acc_r} + {1'b0, frac_val};
        wire [24:0] limit = {1'b0, int_val} + {24'h0, extra_r};
        wire run = div_cfg_r[i][SPCR_DIV_EN_BIT] & root_on_r;
        wire wrap = run & ({1'b0, cnt_r} >= limit);
        wire [31:0] wmask = {1'b1, 2'h0, FRAC ? 5'h1f : 5'h0,
                             24'((25'h1 << IW) - 25'h1)};
        always_ff @(posedge clock or posedge lrst) begin
            if (lrst) begin
                div_cfg_r[i] <= 32'h0;
                cnt_r <= 24'h0;
                acc_r <= 5'h0;
                extra_r <= 1'b0;
                div_en_r[i] <= 1'b0;
            end else if (ce) begin
                if (wr_en & addr_ok & div_hit & (div_idx == 5'(i))) begin
                    div_cfg_r[i] <= pwdata & wmask;
                end
                div_en_r[i] <= wrap;
                if (wrap) begin
                    cnt_r <= 24'h0;
                    acc_r <= acc_sum[4:0];
                    extra_r <= acc_sum[5];
                end else if (run) begin
                    cnt_r <= cnt_r + 24'h1;
                end
            end
        end
    end

    // Main oscillator frequency and lock to the watch crystal
    logic [2:0] imo_code_r;
    logic imo_lock_r;
    logic [11:0] imo_tgt_r;
    logic [15:0] per_cnt_r;
    logic [7:0] trim_r;
    wire [2:0] code_in = (pwdata[2:0] > SPCR_IMO_CODE_MAX) ?
                         SPCR_IMO_CODE_MAX : pwdata[2:0];
    wire [15:0] tgt16 = {4'h0, imo_tgt_r};
    always_ff @(posedge clock or posedge lrst) begin
        if (lrst) begin
            imo_code_r <= SPCR_IMO_CODE_RST;
            imo_lock_r <= 1'b0;
            imo_tgt_r <= SPCR_IMO_TGT_RST;
            per_cnt_r <= 16'h0;
            trim_r <= SPCR_IMO_TRIM_RST;
        end else if (ce) begin
            if (wr_imo) begin
                imo_code_r <= code_in;
                imo_lock_r <= pwdata[SPCR_IMO_LOCK_BIT];
            end
            if (wr_tgt) imo_tgt_r <= pwdata[11:0];
            if (wco_rise) begin
                per_cnt_r <= 16'h0;
                // Trim steps one code per crystal period, saturating
                if (imo_lock_r & (per_cnt_r > tgt16) & (trim_r != 8'h00)) begin
                    trim_r <= trim_r - 8'h1;
                end else if (imo_lock_r & (per_cnt_r < tgt16) &
                             (trim_r != 8'hff)) begin
                    trim_r <= trim_r + 8'h1;
                end
            end else if (per_cnt_r != 16'hffff) begin
                per_cnt_r <= per_cnt_r + 16'h1;
            end
        end
    end

    // Watchdog and real-time counter
    logic [2:0] wdt_ctrl_r;
    logic [31:0] wdt_match_r, wdt_cnt_r;
    wire wdt_tick = wdt_ctrl_r[SPCR_WDT_WCO_BIT] ? wco_rise : ilo_rise;
    wire wdt_hit = wdt_ctrl_r[SPCR_WDT_EN_BIT] & wdt_tick &
                   (wdt_cnt_r == wdt_match_r);
    always_ff @(posedge clock or posedge lrst) begin
        if (lrst) begin
            wdt_ctrl_r <= 3'h0;
            wdt_match_r <= SPCR_WDT_MATCH_RST;
            wdt_cnt_r <= 32'h0;
            wdt_fire_r <= 1'b0;
            sw_rst_r <= 1'b0;
        end else if (ce) begin
            if (wr_wctl) wdt_ctrl_r <= pwdata[2:0];
            if (wr_wmat) wdt_match_r <= pwdata;
            // Any write to the count register services the watchdog
            if (wr_wcnt) begin
                wdt_cnt_r <= 32'h0;
            end else if (wdt_ctrl_r[SPCR_WDT_EN_BIT] & wdt_tick) begin
                wdt_cnt_r <= wdt_cnt_r + 32'h1;
            end
            if (wdt_hit & wdt_ctrl_r[SPCR_WDT_RSTEN_BIT]) begin
                wdt_fire_r <= 1'b1;
            end
            if (wr_swr) sw_rst_r <= 1'b1;
        end
    end

    // Interrupt status, cleared by read, set wins
    logic [2:0] stat_r, mask_r;
    logic irq_r;
    wire [2:0] ev = {root_start & ~root_on_r, wdt_hit,
                     wake_any & ((mode_r == SPCR_SLEEP) |
                                 (mode_r == SPCR_DEEP))};
    wire [2:0] stat_nxt = (rd_stat ? 3'h0 : stat_r) | ev;
    always_ff @(posedge clock or posedge lrst) begin
        if (lrst) begin
            stat_r <= 3'h0;
            mask_r <= 3'h0;
            irq_r <= 1'b0;
            deep_sel_r <= 1'b0;
        end else if (ce) begin
            stat_r <= stat_nxt;
            if (wr_mask) mask_r <= pwdata[2:0];
            if (wr_ctl) deep_sel_r <= pwdata[0];
            irq_r <= |(stat_nxt & (wr_mask ? pwdata[2:0] : mask_r));
        end
    end

    // Read data select
    wire [31:0] rdata =
        div_hit ? div_cfg_r[div_idx] :
        (paddr == SPCR_PWR_CTRL) ? {31'h0, deep_sel_r} :
        (paddr == SPCR_PWR_STAT) ? {28'h0, gate_r.hf_clk, mode_r} :
        (paddr == SPCR_CLK_SEL) ? {27'h0, root_on_r, src_r, src_req_r} :
        (paddr == SPCR_IMO_CFG) ? {23'h0, imo_lock_r, 5'h0, imo_code_r} :
        (paddr == SPCR_IMO_TGT) ? {20'h0, imo_tgt_r} :
        (paddr == SPCR_IMO_TRIM) ? {24'h0, trim_r} :
        (paddr == SPCR_WDT_CTRL) ? {29'h0, wdt_ctrl_r} :
        (paddr == SPCR_WDT_MATCH) ? wdt_match_r :
        (paddr == SPCR_WDT_COUNT) ? wdt_cnt_r :
        (paddr == SPCR_RST_CAUSE) ? {28'h0, cause_r} :
        (paddr == SPCR_INT_STAT) ? {29'h0, stat_r} :
        (paddr == SPCR_INT_MASK) ? {29'h0, mask_r} : 32'h0;

    // APB answer: one wait-free access phase
    always_ff @(posedge clock or posedge lrst) begin
        if (lrst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else if (ce) begin
            pready_r <= setup;
            pslverr_r <= setup & ~addr_ok;
            prdata_r <= (setup & ~pwrite & addr_ok) ? rdata : 32'h0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign gate = gate_r;
    assign power_mode = mode_r;
    assign root_src = src_r;
    assign root_clk_on = root_on_r;
    assign div_clk_en = div_en_r;
    assign imo_freq_code = imo_code_r;
    assign imo_trim = trim_r;
    assign sys_reset = sys_reset_r;
    assign irq = irq_r;
endmodule

/* File: spcr_top_asserts.sv */
// Port checker of the power, clock and reset controller.
// Assumes one clock domain and rst as the async active-high reset.
`timescale 1ns/1ps
module spcr_top_asserts #(
    parameter int NUM_DIV = 18,
    parameter int WAKE_CYC = 1750,
    parameter int RST_HOLD = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and monitors
    input wire logic external_reset_n,
    input wire logic supply_good,
    input wire logic brownout,
    input wire logic [7:0] wake_irq,
    // Controls
    input wire spcr_pkg::spcr_gate_t gate,
    input wire spcr_pkg::spcr_mode_t power_mode,
    input wire spcr_pkg::spcr_src_t root_src,
    input wire logic root_clk_on,
    input wire logic [2:0] imo_freq_code,
    input wire logic sys_reset
);
    import spcr_pkg::*;
    int wake_cnt_r;
    int wake_cnt_nxt;
    assign wake_cnt_nxt = (power_mode == SPCR_WAKE) ? wake_cnt_r + 1 : 0;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_cnt_r <= 0;
        end else begin
            wake_cnt_r <= wake_cnt_nxt;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_no_supply;
        power_mode == SPCR_HOLD && !supply_good ##1 !supply_good [*3];
    endsequence
    a_apb_one_ready: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_err_reads_zero: assert property (pslverr |-> pready && prdata == 0)
        else $error("error response without zero data");
    a_active_all_on: assert property (
        power_mode == SPCR_ACTIVE |-> gate == 4'hf)
        else $error("clock gated in active mode");
    a_sleep_gates_cpu: assert property (
        power_mode == SPCR_SLEEP |-> !gate.cpu_clk && gate.periph_clk)
        else $error("wrong gating in sleep");
    a_sleep_wake_fast: assert property (
        power_mode == SPCR_SLEEP && |wake_irq |-> ##[1:4]
        power_mode == SPCR_ACTIVE)
        else $error("slow wake from sleep");
    a_deep_hf_off: assert property (
        power_mode == SPCR_DEEP |-> !gate.hf_clk)
        else $error("fast clock on in deep sleep");
    a_wake_not_early: assert property (
        $past(power_mode) == SPCR_WAKE && power_mode == SPCR_ACTIVE
        |-> wake_cnt_r >= WAKE_CYC - 1)
        else $error("deep wake too short");
    a_wake_not_late: assert property (wake_cnt_r <= WAKE_CYC + 1)
        else $error("deep wake too long");
    a_hold_no_supply: assert property (
        s_no_supply |-> power_mode == SPCR_HOLD)
        else $error("mode left hold without supply");
    a_bod_resets: assert property (brownout |-> ##[0:3] sys_reset)
        else $error("no reset on brownout");
    a_pin_resets: assert property (
        !external_reset_n |-> ##[0:3] sys_reset)
        else $error("no reset on pin");
    a_switch_quiet: assert property (disable iff (rst || sys_reset)
        !$stable(root_src) |-> !root_clk_on && !$past(root_clk_on))
        else $error("root source changed with clock on");
    a_code_in_range: assert property (
        imo_freq_code <= SPCR_IMO_CODE_MAX)
        else $error("oscillator code above range");
endmodule

bind spcr_top spcr_top_asserts #(
    .NUM_DIV(NUM_DIV),
    .WAKE_CYC(WAKE_CYC),
    .RST_HOLD(RST_HOLD)
) chk_u (.*);

/* File: tb_spcr_top.sv */
// Self-checking bench of the power, clock and reset controller.
// Assumes spcr_top with shortened wake and reset hold counts.
`timescale 1ns/1ps
module tb_spcr_top;
    import spcr_pkg::*;
    localparam int WC = 20;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] wd;
        logic [31:0] rd;
        logic e;
    } spcr_row_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] paddr = 8'h0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, sys_reset, irq, root_clk_on;
    logic external_reset_n = 1'b1, supply_good = 1'b0, brownout = 1'b0;
    logic internal_low_power_osc = 1'b0, watch_crystal_osc = 1'b0;
    logic sleep_req = 1'b0;
    logic [7:0] wake_irq = 8'h0, imo_trim;
    logic [2:0] imo_freq_code;
    logic [17:0] div_clk_en;
    spcr_gate_t gate;
    spcr_mode_t power_mode;
    spcr_src_t root_src;
    int fails = 0, comparisons = 0, n, k, cyc = 0;
    spcr_row_t rows [9];

    spcr_top #(.NUM_DIV(18), .WAKE_CYC(WC), .RST_HOLD(2)) dut_u (.*);

    always #10 clock = ~clock;
    // Slow oscillators derived from the bench count, phase is arbitrary
    always @(posedge clock) begin
        cyc <= cyc + 1;
        internal_low_power_osc <= cyc[3];
        watch_crystal_osc <= cyc[6];
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n, 1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    task automatic wmode(input spcr_mode_t m);
        n = 0;
        while (power_mode !== m && n < 3000) begin
            @(posedge clock);
            n++;
        end
        chk(power_mode, m);
    endtask

    task automatic wrst(input logic v);
        n = 0;
        while (sys_reset !== v && n < 3000) begin
            @(posedge clock);
            n++;
        end
        chk(sys_reset, v);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("mismatch at %0t: run timed out", $time);
        stop_test;
    end

    initial begin
        rows[0] = {1'b0, SPCR_IMO_TGT, 32'h0, 32'h5b9, 1'b0};
        rows[1] = {1'b0, SPCR_WDT_MATCH, 32'h0, 32'hffff, 1'b0};
        rows[2] = {1'b0, SPCR_IMO_CFG, 32'h0, 32'h0, 1'b0};
        rows[3] = {1'b1, SPCR_IMO_TRIM, ~32'h0, 32'h80, 1'b0};
        rows[4] = {1'b0, SPCR_INT_MASK, 32'h0, 32'h0, 1'b0};
        rows[5] = {1'b1, 8'h34, ~32'h0, 32'h0, 1'b1};
        rows[6] = {1'b1, 8'h05, ~32'h0, 32'h0, 1'b1};
        rows[7] = {1'b1, 8'h40, 32'h9fffffff, 32'h8000ffff, 1'b0};
        rows[8] = {1'b1, 8'h84, 32'h9fffffff, 32'h9fffffff, 1'b0};
        repeat (12) @(posedge clock);
        chk(sys_reset, 1'b1);
        rst <= 1'b0;
        repeat (8) @(posedge clock);
        chk(sys_reset, 1'b0);
        chk(power_mode, SPCR_HOLD);
        supply_good <= 1'b1;
        wmode(SPCR_ACTIVE);
        chk(gate, 4'hf);
        $display("power-up done");
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].wd);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rdat, rows[i].rd);
            chk(rerr, rows[i].e);
        end
        $display("register table done");
        apb(1'b1, SPCR_IMO_CFG, 32'h7);
        repeat (2) @(posedge clock);
        chk(imo_freq_code, 3'h6);
        apb(1'b1, SPCR_IMO_CFG, 32'h103);
        repeat (2) @(posedge clock);
        chk(imo_freq_code, 3'h3);
        $display("oscillator code done");
        rd(SPCR_INT_STAT, 32'h4);
        apb(1'b1, SPCR_PWR_CTRL, 32'h0);
        sleep_req <= 1'b1;
        @(posedge clock);
        sleep_req <= 1'b0;
        repeat (2) @(posedge clock);
        chk(power_mode, SPCR_SLEEP);
        chk({gate.periph_clk, gate.cpu_clk}, 2'b10);
        wake_irq <= 8'h80;
        repeat (6) @(posedge clock);
        chk(power_mode, SPCR_ACTIVE);
        chk(irq, 1'b0);
        wake_irq <= 8'h0;
        apb(1'b1, SPCR_INT_MASK, 32'h1);
        repeat (2) @(posedge clock);
        chk(irq, 1'b1);
        rd(SPCR_INT_STAT, 32'h1);
        repeat (2) @(posedge clock);
        chk(irq, 1'b0);
        rd(SPCR_INT_STAT, 32'h0);
        $display("sleep and interrupt done");
        apb(1'b1, SPCR_PWR_CTRL, 32'h1);
        sleep_req <= 1'b1;
        @(posedge clock);
        sleep_req <= 1'b0;
        repeat (2) @(posedge clock);
        chk(power_mode, SPCR_DEEP);
        chk(gate.hf_clk, 1'b0);
        wake_irq <= 8'h01;
        wmode(SPCR_WAKE);
        wake_irq <= 8'h0;
        repeat (WC - 2) @(posedge clock);
        chk(power_mode, SPCR_WAKE);
        repeat (4) @(posedge clock);
        chk(power_mode, SPCR_ACTIVE);
        $display("deep sleep done");
        apb(1'b1, SPCR_CLK_SEL, 32'h1);
        repeat (20) @(posedge clock);
        chk(root_src, SPCR_SRC_ECO);
        rd(SPCR_CLK_SEL, 32'h15);
        apb(1'b1, 8'h40, 32'h80000003);
        repeat (8) @(posedge clock);
        k = 0;
        repeat (40) begin
            @(posedge clock);
            k += div_clk_en[0];
        end
        chk(k, 10);
        chk(imo_trim > 8'h80, 1'b1);
        $display("clock switch and divider done");
        for (int s = 0; s < 4; s++) begin
            case (s)
                0: begin
                    apb(1'b1, SPCR_WDT_MATCH, 32'h4);
                    apb(1'b1, SPCR_WDT_COUNT, 32'h0);
                    apb(1'b1, SPCR_WDT_CTRL, 32'h3);
                end
                1: apb(1'b1, SPCR_SW_RESET, 32'h1);
                2: external_reset_n <= 1'b0;
                default: brownout <= 1'b1;
            endcase
            wrst(1'b1);
            repeat (5) @(posedge clock);
            external_reset_n <= 1'b1;
            brownout <= 1'b0;
            wrst(1'b0);
            wmode(SPCR_ACTIVE);
            rd(SPCR_RST_CAUSE, 32'h1 << s);
            apb(1'b1, SPCR_RST_CAUSE, 32'hf);
            rd(SPCR_RST_CAUSE, 32'h0);
            $display("reset source %0d done", s);
        end
        stop_test;
    end
endmodule
